/* File: hdl/ctl_pkg.sv */
// Shared constants, field layouts and types of the I/O read and accumulator unit
package ctl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD_HDR = 8'h00;
  localparam logic [7:0] OFF_CMD_VAL = 8'h04;
  localparam logic [7:0] OFF_CMD_GO  = 8'h08;
  localparam logic [7:0] OFF_CFG     = 8'h0c;
  localparam logic [7:0] OFF_RPL_HDR = 8'h10;
  localparam logic [7:0] OFF_RPL_VAL = 8'h14;
  localparam logic [7:0] OFF_RPL_STA = 8'h18;
  localparam logic [7:0] OFF_ACCU    = 8'h1c;
  localparam logic [7:0] OFF_FLAGS   = 8'h20;
  localparam logic [7:0] OFF_DOUT    = 8'h24;

  // Opcodes and status codes
  localparam logic [7:0] OP_INPUT_READ = 8'h0f;
  localparam logic [7:0] OP_ACCUMULATOR_INSTR_A       = 8'h13;
  localparam logic [7:0] OP_COMPARE    = 8'h14;
  localparam logic [7:0] ST_OK         = 8'h64;
  localparam logic [7:0] ST_BAD_SUM    = 8'h01;
  localparam logic [7:0] ST_BAD_CMD    = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE   = 8'h03;

  // Banks and special ports
  localparam logic [7:0] BANK_DIN        = 8'h00;
  localparam logic [7:0] BANK_ANA        = 8'h01;
  localparam logic [7:0] BANK_DOUT       = 8'h02;
  localparam logic [7:0] PORT_LAST_LINE  = 8'h07;
  localparam logic [7:0] PORT_LAST_ANA   = 8'h03;
  localparam logic [7:0] PORT_SUPPLY_RAW = 8'h04;
  localparam logic [7:0] PORT_TEMP_RAW   = 8'h05;
  localparam logic [7:0] PORT_EXTRA_ANALOG_INPUT_LINE = 8'h06;
  localparam logic [7:0] PORT_SUPPLY_DV  = 8'h08;
  localparam logic [7:0] PORT_TEMP_C     = 8'h09;
  localparam logic [7:0] PORT_ENABLE     = 8'h0a;
  localparam logic [7:0] PORT_ALL        = 8'hff;
  localparam int         ANA_CHANNELS    = 6;
  localparam int         LINES           = 8;

  // Reset values
  localparam logic [7:0] MOD_ADDR_RST  = 8'h01;
  localparam logic [7:0] HOST_ADDR_RST = 8'h02;

  // Calculate operation types
  typedef enum logic [7:0] {
    ACCUMULATOR_INSTR_A_ADD  = 8'h00,
    ACCUMULATOR_INSTR_A_SUB  = 8'h01,
    ACCUMULATOR_INSTR_A_MUL  = 8'h02,
    ACCUMULATOR_INSTR_A_DIV  = 8'h03,
    ACCUMULATOR_INSTR_A_MOD  = 8'h04,
    ACCUMULATOR_INSTR_A_AND  = 8'h05,
    ACCUMULATOR_INSTR_A_OR   = 8'h06,
    ACCUMULATOR_INSTR_A_XOR  = 8'h07,
    ACCUMULATOR_INSTR_A_NOT  = 8'h08,
    ACCUMULATOR_INSTR_A_LOAD = 8'h09
  } accumulator_instr_a_e;

  typedef enum logic [1:0] {
    EXEC_IDLE = 2'b01,
    EXEC_RUN  = 2'b10
  } exec_e;

  // Frame header, first byte in the top lane
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] op_type;
    logic [7:0] bank;
  } cmd_hdr_s;

  typedef struct packed {
    logic [7:0] host;
    logic [7:0] module_addr;
    logic [7:0] status;
    logic [7:0] opcode;
  } rpl_hdr_s;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        standalone;
    logic [7:0]  checksum;
  } go_s;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] host;
    logic [7:0] module_addr;
    logic [6:0] rsvd2;
    logic       res16;
  } cfg_s;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [7:0]  cond;
    logic        lt;
    logic        gt;
    logic        eq;
  } flags_s;

  typedef struct packed {
    logic [21:0] rsvd;
    logic        busy;
    logic        valid;
    logic [7:0]  checksum;
  } rpl_sta_s;

  // Converter results presented by the sampling logic
  typedef struct packed {
    logic [ANA_CHANNELS-1:0][15:0] ana;
    logic [9:0]                    supply_raw;
    logic [9:0]                    temp_raw;
    logic [15:0]                   supply_dv;
    logic signed [15:0]            temp_c;
  } adc_s;

  localparam int RES_SHIFT = 6;

  // Eight-bit sum of the eight header and value bytes
  function automatic logic [7:0] sum8(input logic [31:0] a, input logic [31:0] b);
    sum8 = a[31:24] + a[23:16] + a[15:8] + a[7:0] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
  endfunction
endpackage

/* File: hdl/sync2.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } st_s;

  st_s s_q;
  st_s s_d;

  // First stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stab;
endmodule // sync2

/* File: hdl/accumulator_instr_a_unit.sv */
// Signed accumulator arithmetic and compare flags
`timescale 1ns/100ps
module accumulator_instr_a_unit (
  input  wire logic        [7:0]  op_type,
  input  wire logic signed [31:0] accu,
  input  wire logic signed [31:0] operand,
  output logic signed      [31:0] result,
  output logic                    type_ok,
  output logic                    eq,
  output logic                    gt,
  output logic                    lt
);
  // Operation select; a zero divisor keeps the accumulator
  always_comb begin
    result  = accu;
    type_ok = 1'b1;
    case (op_type)
      ctl_pkg::ACCUMULATOR_INSTR_A_ADD:  result = accu + operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_SUB:  result = accu - operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_MUL:  result = accu * operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_DIV:  if (operand != '0) result = accu / operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_MOD:  if (operand != '0) result = accu % operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_AND:  result = accu & operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_OR:   result = accu | operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_XOR:  result = accu ^ operand;
      ctl_pkg::ACCUMULATOR_INSTR_A_NOT:  result = ~accu;
      ctl_pkg::ACCUMULATOR_INSTR_A_LOAD: result = operand;
      default:            type_ok = 1'b0;
    endcase
  end

  // Signed relations of accumulator to operand
  always_comb begin
    eq = (accu == operand);
    gt = (accu > operand);
    lt = (accu < operand);
  end
endmodule // accumulator_instr_a_unit

/* File: hdl/io_read_accumulator_compare_unit.sv */
// Command executor for input read, calculate and compare, with APB registers
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module io_read_accumulator_compare_unit (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           digital_input_line,
  input  wire logic                 enable_in,
  input  wire ctl_pkg::adc_s        adc,
  output logic      [7:0]           digital_output_line
);
  typedef struct packed {
    ctl_pkg::exec_e    state;
    ctl_pkg::cmd_hdr_s cmd_hdr;
    logic [31:0]       cmd_val;
    logic [7:0]        cmd_sum;
    logic              standalone;
    ctl_pkg::cfg_s     cfg;
    logic [31:0]       accu;
    logic              eq;
    logic              gt;
    logic              lt;
    ctl_pkg::rpl_hdr_s rpl_hdr;
    logic [31:0]       rpl_val;
    logic              rpl_valid;
    logic [7:0]        dout;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } st_s;

  st_s                s_q;
  st_s                s_d;
  logic [8:0]         pins;
  logic [31:0]        accumulator_instr_a_res;
  logic               accumulator_instr_a_ok;
  logic               cmp_eq;
  logic               cmp_gt;
  logic               cmp_lt;
  logic [31:0]        rd_val;
  logic               rd_hit;
  logic [31:0]        in_val;
  logic               in_ok;
  logic [7:0]         cond;
  logic               access;
  logic               commit;

  // Pin levels come from outside the clock domain
  sync2 #(.W(9)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({enable_in, digital_input_line}),
    .q       (pins)
  );

  accumulator_instr_a_unit u_accumulator_instr_a (
    .op_type (s_q.cmd_hdr.op_type),
    .accu    (s_q.accu),
    .operand (s_q.cmd_val),
    .result  (accumulator_instr_a_res),
    .type_ok (accumulator_instr_a_ok),
    .eq      (cmp_eq),
    .gt      (cmp_gt),
    .lt      (cmp_lt)
  );

  // Scale an analog sample to the selected resolution
  function automatic logic [31:0] ana_scale(input logic [15:0] v, input logic res16);
    logic [15:0] r;
    r = v >> ctl_pkg::RES_SHIFT;
    ana_scale = res16 ? {16'h0000, v} : {16'h0000, r};
  endfunction

  // Jump conditions ZE NZ EQ NE GT GE LT LE from stored flags
  always_comb begin
    cond[0] = s_q.eq;
    cond[1] = !s_q.eq;
    cond[2] = s_q.eq;
    cond[3] = !s_q.eq;
    cond[4] = s_q.gt;
    cond[5] = s_q.gt | s_q.eq;
    cond[6] = s_q.lt;
    cond[7] = s_q.lt | s_q.eq;
  end

  // Line selected by bank and port; value bytes are not looked at
  always_comb begin
    in_val = '0;
    in_ok  = 1'b1;
    case (s_q.cmd_hdr.bank)
      ctl_pkg::BANK_DIN: begin
        if (s_q.cmd_hdr.op_type <= ctl_pkg::PORT_LAST_LINE) begin
          in_val[0] = pins[s_q.cmd_hdr.op_type[2:0]];
        end else if (s_q.cmd_hdr.op_type == ctl_pkg::PORT_ENABLE) begin
          in_val[0] = pins[ctl_pkg::LINES];
        end else if (s_q.cmd_hdr.op_type == ctl_pkg::PORT_ALL) begin
          in_val[ctl_pkg::LINES-1:0] = pins[ctl_pkg::LINES-1:0];
        end else begin
          in_ok = 1'b0;
        end
      end
      ctl_pkg::BANK_ANA: begin
        case (s_q.cmd_hdr.op_type)
          ctl_pkg::PORT_SUPPLY_RAW: in_val = {22'h0, adc.supply_raw};
          ctl_pkg::PORT_TEMP_RAW:   in_val = {22'h0, adc.temp_raw};
          ctl_pkg::PORT_SUPPLY_DV:  in_val = {16'h0000, adc.supply_dv};
          ctl_pkg::PORT_TEMP_C:     in_val = 32'(adc.temp_c);
          default: begin
            if (s_q.cmd_hdr.op_type <= ctl_pkg::PORT_LAST_ANA) begin
              in_val = ana_scale(adc.ana[s_q.cmd_hdr.op_type[2:0]], s_q.cfg.res16);
            end else if (s_q.cmd_hdr.op_type == ctl_pkg::PORT_EXTRA_ANALOG_INPUT_LINE ||
                         s_q.cmd_hdr.op_type == ctl_pkg::PORT_LAST_LINE) begin
              in_val = ana_scale(adc.ana[s_q.cmd_hdr.op_type[2:0] - 3'h2], s_q.cfg.res16);
            end else begin
              in_ok = 1'b0;
            end
          end
        endcase
      end
      ctl_pkg::BANK_DOUT: begin
        if (s_q.cmd_hdr.op_type <= ctl_pkg::PORT_LAST_LINE) begin
          in_val[0] = s_q.dout[s_q.cmd_hdr.op_type[2:0]];
        end else begin
          in_ok = 1'b0;
        end
      end
      default: in_ok = 1'b0;
    endcase
  end

  // Register read decode; unmapped offsets answer with an error
  always_comb begin
    ctl_pkg::flags_s   fl;
    ctl_pkg::rpl_sta_s rs;
    fl          = '0;
    rs          = '0;
    fl.cond     = cond;
    fl.lt       = s_q.lt;
    fl.gt       = s_q.gt;
    fl.eq       = s_q.eq;
    rs.busy     = (s_q.state == ctl_pkg::EXEC_RUN);
    rs.valid    = s_q.rpl_valid;
    rs.checksum = ctl_pkg::sum8(s_q.rpl_hdr, s_q.rpl_val);
    rd_hit      = 1'b1;
    rd_val      = '0;
    case (paddr)
      ctl_pkg::OFF_CMD_HDR: rd_val = s_q.cmd_hdr;
      ctl_pkg::OFF_CMD_VAL: rd_val = s_q.cmd_val;
      ctl_pkg::OFF_CMD_GO:  rd_val = {23'h0, s_q.standalone, s_q.cmd_sum};
      ctl_pkg::OFF_CFG:     rd_val = s_q.cfg;
      ctl_pkg::OFF_RPL_HDR: rd_val = s_q.rpl_hdr;
      ctl_pkg::OFF_RPL_VAL: rd_val = s_q.rpl_val;
      ctl_pkg::OFF_RPL_STA: rd_val = rs;
      ctl_pkg::OFF_ACCU:    rd_val = s_q.accu;
      ctl_pkg::OFF_FLAGS:   rd_val = fl;
      ctl_pkg::OFF_DOUT:    rd_val = {24'h000000, s_q.dout};
      default:              rd_hit = 1'b0;
    endcase
  end

  // One wait state: answer is built in the first access cycle
  assign access = psel & penable;
  assign commit = access & s_q.pready & pwrite & !s_q.pslverr;

  // Bus slave, command launch and execution
  always_comb begin
    ctl_pkg::go_s go;
    go        = pwdata;
    s_d       = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (access && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !rd_hit;
      s_d.prdata  = pwrite ? 32'h00000000 : rd_val;
    end
    if (commit) begin
      case (paddr)
        ctl_pkg::OFF_CMD_HDR: s_d.cmd_hdr = pwdata;
        ctl_pkg::OFF_CMD_VAL: s_d.cmd_val = pwdata;
        ctl_pkg::OFF_CFG: begin
          s_d.cfg       = pwdata;
          s_d.cfg.rsvd  = '0;
          s_d.cfg.rsvd2 = '0;
        end
        ctl_pkg::OFF_DOUT:    s_d.dout = pwdata[ctl_pkg::LINES-1:0];
        ctl_pkg::OFF_CMD_GO: begin
          // A launch while busy is dropped; the frame in flight completes
          if (s_q.state == ctl_pkg::EXEC_IDLE) begin
            s_d.cmd_sum    = go.checksum;
            s_d.standalone = go.standalone;
            s_d.rpl_valid  = 1'b0;
            s_d.state      = ctl_pkg::EXEC_RUN;
          end
        end
        default: ;
      endcase
    end
    unique case (s_q.state)
      ctl_pkg::EXEC_IDLE: ;
      ctl_pkg::EXEC_RUN: begin
        s_d.state               = ctl_pkg::EXEC_IDLE;
        s_d.rpl_hdr.host        = s_q.cfg.host;
        s_d.rpl_hdr.module_addr = s_q.cfg.module_addr;
        s_d.rpl_hdr.opcode      = s_q.cmd_hdr.opcode;
        s_d.rpl_hdr.status      = ctl_pkg::ST_OK;
        s_d.rpl_val             = '0;
        // Frames for another module produce no reply
        s_d.rpl_valid = !s_q.standalone && (s_q.cmd_hdr.addr == s_q.cfg.module_addr);
        if (s_q.cmd_hdr.addr != s_q.cfg.module_addr) begin
          s_d.rpl_hdr = s_q.rpl_hdr;
          s_d.rpl_val = s_q.rpl_val;
        end else if (ctl_pkg::sum8(s_q.cmd_hdr, s_q.cmd_val) != s_q.cmd_sum) begin
          s_d.rpl_hdr.status = ctl_pkg::ST_BAD_SUM;
        end else begin
          case (s_q.cmd_hdr.opcode)
            ctl_pkg::OP_INPUT_READ: begin
              if (!in_ok) begin
                s_d.rpl_hdr.status = ctl_pkg::ST_BAD_TYPE;
              end else begin
                s_d.rpl_val = in_val;
                if (s_q.standalone || (s_q.cmd_hdr.bank == ctl_pkg::BANK_DIN &&
                                       s_q.cmd_hdr.op_type == ctl_pkg::PORT_ALL)) begin
                  s_d.accu = in_val;
                end
              end
            end
            ctl_pkg::OP_ACCUMULATOR_INSTR_A: begin
              if (!accumulator_instr_a_ok) begin
                s_d.rpl_hdr.status = ctl_pkg::ST_BAD_TYPE;
              end else begin
                s_d.accu    = accumulator_instr_a_res;
                s_d.rpl_val = s_q.cmd_val;
              end
            end
            ctl_pkg::OP_COMPARE: begin
              s_d.eq      = cmp_eq;
              s_d.gt      = cmp_gt;
              s_d.lt      = cmp_lt;
              s_d.rpl_val = s_q.cmd_val;
            end
            default: s_d.rpl_hdr.status = ctl_pkg::ST_BAD_CMD;
          endcase
        end
      end
    endcase
  end

  // State register; reset holds the documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                 <= '0;
      s_q.state           <= ctl_pkg::EXEC_IDLE;
      s_q.cfg.module_addr <= ctl_pkg::MOD_ADDR_RST;
      s_q.cfg.host        <= ctl_pkg::HOST_ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata              = s_q.prdata;
  assign pready              = s_q.pready;
  assign pslverr             = s_q.pslverr;
  assign digital_output_line = s_q.dout;
endmodule // io_read_accumulator_compare_unit

/* File: sim/ioacc_chk_sva.sv */
// Port checks for the command executor, bound to its top module
`timescale 1ns/100ps
module ioacc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  digital_output_line
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic dwr;
  // Access phase and committed output register write
  assign acc = psel && penable;
  assign dwr = acc && pready && pwrite && paddr == ctl_pkg::OFF_DOUT;
  property p_one_wait; psel && !penable ##1 acc |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not in second access cycle");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_in_access; pready |-> acc; endproperty
  a_in_access: assert property (p_in_access) else $error("pready outside access phase");
  property p_err_only; pslverr |-> pready; endproperty
  a_err_only: assert property (p_err_only) else $error("pslverr without pready");
  property p_unmapped; pready && paddr > ctl_pkg::OFF_DOUT |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; pready && paddr <= ctl_pkg::OFF_DOUT && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_dout_wr; dwr |=> digital_output_line == $past(pwdata[7:0]); endproperty
  a_dout_wr: assert property (p_dout_wr) else $error("output lines miss write");
  property p_dout_hold; !dwr |=> $stable(digital_output_line); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("output lines moved");
  property p_dout_rd; pready && !pwrite && paddr == ctl_pkg::OFF_DOUT |-> prdata[7:0] == digital_output_line;
  endproperty
  a_dout_rd: assert property (p_dout_rd) else $error("output readback wrong");
  c_dout_wr: cover property (dwr);
  c_refused: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
endmodule // ioacc_chk

bind io_read_accumulator_compare_unit ioacc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .digital_output_line(digital_output_line));

/* File: sim/io_pins_model.sv */
// Pin and converter environment seen by the executor
`timescale 1ns/100ps
module io_pins_model (
  input  wire logic    pclk,
  input  wire logic [7:0] din_set,
  input  wire logic    en_set,
  output logic [7:0]   digital_input_line,
  output logic         enable_in,
  output ctl_pkg::adc_s adc
);
  // Pins change after the edge, as real levels would
  always_ff @(posedge pclk) begin
    digital_input_line <= din_set;
    enable_in <= en_set;
  end
  // Fixed conversions, distinct per channel so a swapped index shows
  always_comb begin
    for (int i = 0; i < ctl_pkg::ANA_CHANNELS; i++) begin
      adc.ana[i] = 16'h0fc0 + 16'h2000 * 16'(i);
    end
    adc.supply_raw = 10'h2a5;
    adc.temp_raw = 10'h155;
    adc.supply_dv = 16'h00f0;
    adc.temp_c = 16'sh0019;
  end
endmodule // io_pins_model

/* File: sim/testbench.sv */
// Bench issuing commands over the register bus
`timescale 1ns/100ps
module testbench;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, enable_in, en_set, err;
  logic [7:0]    paddr, din_set, digital_input_line, digital_output_line;
  logic [31:0]   pwdata, prdata, rd;
  logic [10:0]   fl;
  ctl_pkg::adc_s adc;
  int            n_mismatch, check_count, ix;

  io_read_accumulator_compare_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_input_line(digital_input_line), .enable_in(enable_in), .adc(adc),
    .digital_output_line(digital_output_line));
  io_pins_model i_pins (.pclk(pclk), .din_set(din_set), .en_set(en_set),
    .digital_input_line(digital_input_line), .enable_in(enable_in), .adc(adc));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; values read here are those sampled at the edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Frame to module 1; bad adds a checksum error
  task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v, input logic sa, input logic [7:0] bad);
    logic [31:0] h;
    logic [7:0]  s;
    h = {8'h01, op, ty, bk};
    s = h[31:24] + h[23:16] + h[15:8] + h[7:0] + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad;
    apb(1'b1, ctl_pkg::OFF_CMD_HDR, h);
    apb(1'b1, ctl_pkg::OFF_CMD_VAL, v);
    apb(1'b1, ctl_pkg::OFF_CMD_GO, {23'h0, sa, s});
  endtask

  task automatic hdr(input logic [7:0] op, input logic [7:0] st);
    apb(1'b0, ctl_pkg::OFF_RPL_HDR, 32'h0);
    chk(rd, {8'h02, 8'h01, st, op});
  endtask

  // Full reply check: header, value, valid and sum
  task automatic rply(input logic [7:0] op, input logic [31:0] v);
    logic [7:0] s;
    hdr(op, ctl_pkg::ST_OK);
    s = 8'h02 + 8'h01 + ctl_pkg::ST_OK + op + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    apb(1'b0, ctl_pkg::OFF_RPL_VAL, 32'h0);
    chk(rd, v);
    apb(1'b0, ctl_pkg::OFF_RPL_STA, 32'h0);
    chk(rd[9:0], {2'b01, s});
  endtask

  task automatic input_read_instr(input logic [7:0] p, input logic [7:0] b, input logic [31:0] e);
    cmd(ctl_pkg::OP_INPUT_READ, p, b, 32'h0, 1'b0, 8'h0);
    rply(ctl_pkg::OP_INPUT_READ, e);
  endtask

  function automatic logic [31:0] accumulator_instr_a(input int t, input logic signed [31:0] a, input logic signed [31:0] b);
    case (t)
      0: accumulator_instr_a = a + b;
      1: accumulator_instr_a = a - b;
      2: accumulator_instr_a = a * b;
      3: accumulator_instr_a = a / b;
      4: accumulator_instr_a = a % b;
      5: accumulator_instr_a = a & b;
      6: accumulator_instr_a = a | b;
      7: accumulator_instr_a = a ^ b;
      8: accumulator_instr_a = ~a;
      default: accumulator_instr_a = b;
    endcase
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    din_set = 8'h5a;
    en_set = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ctl_pkg::OFF_CFG, 32'h0);
    chk(rd, 32'h00020100);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ctl_pkg::OFF_DOUT, 32'ha5);
    for (int i = 0; i < 8; i++) begin
      input_read_instr(8'(i), 8'h02, 32'((8'ha5 >> i) & 8'h01));
      input_read_instr(8'(i), 8'h00, 32'((8'h5a >> i) & 8'h01));
    end
    input_read_instr(8'h0a, 8'h00, 32'h1);
    // Disabled level must reach the reply after the two-flop delay
    en_set <= 1'b0;
    repeat (4) @(posedge pclk);
    input_read_instr(8'h0a, 8'h00, 32'h0);
    apb(1'b0, ctl_pkg::OFF_ACCU, 32'h0);
    chk(rd, 32'h0);
    cmd(ctl_pkg::OP_INPUT_READ, 8'hff, 8'h00, 32'h0, 1'b0, 8'h0);
    apb(1'b0, ctl_pkg::OFF_ACCU, 32'h0);
    chk(rd, 32'h5a);
    // Both resolutions over the six analog channel ports; supply and temperature ports 4, 5, 8 and 9 are left out
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, ctl_pkg::OFF_CFG, 32'h00020100 | r);
      for (int p = 0; p < 8; p++) begin
        ix = (p < 4) ? p : p - 2;
        if (p != 4 && p != 5) input_read_instr(8'(p), 8'h01, (32'h0fc0 + 32'h2000 * ix) >> (r ? 0 : 6));
      end
    end
    input_read_instr(8'h04, 8'h01, 32'h2a5);
    input_read_instr(8'h05, 8'h01, 32'h155);
    input_read_instr(8'h08, 8'h01, 32'h0f0);
    input_read_instr(8'h09, 8'h01, 32'h019);
    cmd(ctl_pkg::OP_INPUT_READ, 8'h03, 8'h00, 32'h0, 1'b1, 8'h0);
    apb(1'b0, ctl_pkg::OFF_ACCU, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, ctl_pkg::OFF_RPL_STA, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    for (int t = 0; t < 10; t++) begin
      cmd(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 8'h09, 8'h00, -32'sd7, 1'b0, 8'h0);
      cmd(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 8'(t), 8'h00, 32'h3, 1'b0, 8'h0);
      rply(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 32'h3);
      apb(1'b0, ctl_pkg::OFF_ACCU, 32'h0);
      chk(rd, accumulator_instr_a(t, -32'sd7, 32'sd3));
    end
    cmd(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 8'h0a, 8'h00, 32'h3, 1'b0, 8'h0);
    hdr(ctl_pkg::OP_ACCUMULATOR_INSTR_A, ctl_pkg::ST_BAD_TYPE);
    // Compare against values below, equal, above and negative
    cmd(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 8'h09, 8'h00, 32'h5, 1'b0, 8'h0);
    for (int v = -1; v < 7; v++) begin
      cmd(ctl_pkg::OP_COMPARE, 8'h00, 8'h00, 32'(v), 1'b0, 8'h0);
      fl[0] = (v == 5);
      fl[1] = (5 > v);
      fl[2] = (5 < v);
      fl[10:3] = {fl[2] | fl[0], fl[2], fl[1] | fl[0], fl[1], !fl[0], fl[0], !fl[0], fl[0]};
      apb(1'b0, ctl_pkg::OFF_FLAGS, 32'h0);
      chk(rd[10:0], {21'h0, fl});
    end
    cmd(ctl_pkg::OP_ACCUMULATOR_INSTR_A, 8'h09, 8'h00, 32'h77, 1'b0, 8'h1);
    hdr(ctl_pkg::OP_ACCUMULATOR_INSTR_A, ctl_pkg::ST_BAD_SUM);
    apb(1'b0, ctl_pkg::OFF_ACCU, 32'h0);
    chk(rd, 32'h5);
    cmd(8'h0e, 8'h00, 8'h00, 32'h0, 1'b0, 8'h0);
    hdr(8'h0e, ctl_pkg::ST_BAD_CMD);
    end_of_test();
  end
endmodule // testbench
